// *** io_instr_unit.sv ***
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module io_instr_unit
  import io_instr_pkg::*;
#(
  parameter int NUM_ENC = 24,
  parameter int DIN_W   = 32
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Shaft encoders
  input  wire logic [NUM_ENC*ENC_W-1:0] enc_gray,
  // Discrete inputs
  input  wire logic [DIN_W-1:0]  din,
  // Analog output converter
  output dac_cmd_t               dac_cmd,
  output logic                   dac_stb,
  // Number memory store
  output nm_wr_t                 nm_wr,
  output logic                   nm_stb,
  // Discrete output relays
  output dout_cmd_t              dout_cmd,
  output logic                   dout_stb,
  // Print path
  output logic      [WORD_W-1:0] print_word,
  output logic      [WORD_W-1:0] periph_word
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  st_t               st_ff;
  instr_t            instr_ff;
  logic [WORD_W-1:0] acc_ff;
  logic [WORD_W-1:0] tr_ff;
  logic [WORD_W-1:0] print_ff;
  logic [WORD_W-1:0] periph_ff;
  logic [DATA_W-1:0] rdata_ff;
  dac_cmd_t          dac_ff;
  nm_wr_t            nm_ff;
  dout_cmd_t         dout_ff;
  logic              dac_stb_ff;
  logic              nm_stb_ff;
  logic              dout_stb_ff;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire        setup     = psel && !penable;
  wire        access    = psel && penable;
  wire        hit_instr = paddr == OFF_INSTR;
  wire        hit_acc   = paddr == OFF_ACC;
  wire        hit_tr    = paddr == OFF_TR;
  wire        hit_ro    = paddr == OFF_PRINT || paddr == OFF_PERIPH
                          || paddr == OFF_DIN || paddr == OFF_STATUS;
  wire        hit       = hit_instr || hit_acc || hit_tr || hit_ro;
  wire        wr_ok     = access && pwrite && hit;
  wire        wr_instr  = wr_ok && hit_instr;
  wire        wr_acc    = wr_ok && hit_acc;
  wire        wr_tr     = wr_ok && hit_tr;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire        exec      = st_ff == st_exec;
  wire        do_ain    = exec && instr_ff.op == op_mux_analog_in;
  wire        do_aout   = exec && (instr_ff.op == op_mux_analog_out
                                   || instr_ff.op == op_mux_analog_out_alt);
  wire        do_dout   = exec && instr_ff.op == op_mux_discrete_out;
  wire        do_print  = exec && instr_ff.op == op_fast_print;
  // Address field taken only from the low word bits
  wire instr_t nxt_instr = '{op: op_t'(pwdata[OP_LSB +: OP_W]),
                             addr: pwdata[NMAD_W-1:0]};

  // ----------------------------------------
  // Gray input path
  // ----------------------------------------
  wire logic [AIN_SEL_W-1:0] ain_sel = instr_ff.addr[AIN_SEL_W-1:0];
  wire        ain_valid = 32'(ain_sel) < NUM_ENC;
  // Out-of-range selects read as zero rather than wrap onto another shaft
  wire logic [ENC_W-1:0] sel_gray =
    ain_valid ? enc_gray[32'(ain_sel)*ENC_W +: ENC_W] : '0;
  logic [ENC_W-1:0] sel_bin;

  assign sel_bin[ENC_W-1] = sel_gray[ENC_W-1];
  for (genvar gi = 0; gi < ENC_W-1; gi++) begin : g_gray
    assign sel_bin[gi] = sel_gray[gi] ^ sel_bin[gi+1];
  end

  // Positive sign, low bits cleared; binary only reaches the accumulator
  wire logic [WORD_W-1:0] nxt_acc_ain =
    {1'b0, sel_bin, {(MAG_W-ENC_W){1'b0}}};

  // ----------------------------------------
  // Analog output path
  // ----------------------------------------
  // Lower magnitude bits are dropped, never rounded
  wire logic [DAC_MAG_W-1:0] tr_top = tr_ff[MAG_W-1 -: DAC_MAG_W];
  wire logic [DAC_W-1:0] dac_mag = {1'b0, tr_top};
  wire logic [DAC_W-1:0] nxt_code =
    tr_ff[SIGN_B] ? DAC_MID - dac_mag : DAC_MID + dac_mag;
  wire dac_cmd_t nxt_dac = '{chan: instr_ff.addr[AOUT_SEL_W-1:0],
                             code: nxt_code};
  wire nm_wr_t nxt_nm = '{addr: instr_ff.addr, data: tr_ff};
  wire dout_cmd_t nxt_dout = '{chan: instr_ff.addr[DOUT_SEL_W-1:0],
                               on: acc_ff[SIGN_B]};

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [DATA_W-1:0] status_word =
    DATA_W'({exec, instr_ff.op});
  wire logic [DATA_W-1:0] nxt_rdata =
    hit_instr  ? DATA_W'(instr_ff) :
    hit_acc    ? DATA_W'(acc_ff) :
    hit_tr     ? DATA_W'(tr_ff) :
    paddr == OFF_PRINT  ? DATA_W'(print_ff) :
    paddr == OFF_PERIPH ? DATA_W'(periph_ff) :
    paddr == OFF_DIN    ? DATA_W'(din) :
    paddr == OFF_STATUS ? status_word : '0;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // One cycle of execution, in the cycle after the bus access that writes the instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff    <= st_idle;
      instr_ff <= '{op: op_none, addr: '0};
    end else begin
      st_ff <= wr_instr ? st_exec : st_idle;
      if (wr_instr) begin
        instr_ff <= nxt_instr;
      end
    end
  end

  // ----------------------------------------
  // Processor registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= '0;
      tr_ff  <= '0;
    end else begin
      if (do_ain) begin
        acc_ff <= nxt_acc_ain;
      end else if (wr_acc) begin
        acc_ff <= pwdata[WORD_W-1:0];
      end
      // Analog-out never touches the transfer register
      if (wr_tr) begin
        tr_ff <= pwdata[WORD_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_ff      <= '0;
      nm_ff       <= '0;
      dout_ff     <= '0;
      dac_stb_ff  <= 1'b0;
      nm_stb_ff   <= 1'b0;
      dout_stb_ff <= 1'b0;
    end else begin
      dac_stb_ff  <= do_aout;
      nm_stb_ff   <= do_aout;
      dout_stb_ff <= do_dout;
      if (do_aout) begin
        dac_ff <= nxt_dac;
        nm_ff  <= nxt_nm;
      end
      if (do_dout) begin
        dout_ff <= nxt_dout;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      print_ff  <= '0;
      periph_ff <= '0;
    end else begin
      if (do_print) begin
        print_ff <= acc_ff;
      end
      periph_ff <= print_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else if (setup && !pwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata      = rdata_ff;
  assign pready      = 1'b1;
  assign pslverr     = access && !hit;
  assign dac_cmd     = dac_ff;
  assign dac_stb     = dac_stb_ff;
  assign nm_wr       = nm_ff;
  assign nm_stb      = nm_stb_ff;
  assign dout_cmd    = dout_ff;
  assign dout_stb    = dout_stb_ff;
  assign print_word  = print_ff;
  assign periph_word = periph_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_gray_inverse: assert property (
    sel_gray == (sel_bin ^ (sel_bin >> 1)))
    else $error("gray to binary mismatch");

  a_ain_result: assert property (
    do_ain |=> acc_ff == {1'b0, $past(sel_bin), {(MAG_W-ENC_W){1'b0}}})
    else $error("analog input not placed in accumulator");

  a_ain_select: assert property (
    do_ain && ain_valid |->
    sel_gray == enc_gray[32'(ain_sel)*ENC_W +: ENC_W])
    else $error("wrong encoder selected");

  a_one_period: assert property (
    wr_instr |=> exec ##1 !exec)
    else $error("instruction not executed in one period");

  a_tr_kept: assert property (
    do_aout && !wr_tr |=> $stable(tr_ff))
    else $error("transfer register changed by analog out");

  a_dac_code: assert property (
    dac_stb |-> dac_cmd.code == ($past(tr_ff[SIGN_B])
      ? DAC_MID - {1'b0, $past(tr_top)}
      : DAC_MID + {1'b0, $past(tr_top)}))
    else $error("converter code mismatch");

  a_nm_store: assert property (
    do_aout |=> nm_stb && dac_stb && nm_wr.data == $past(tr_ff)
      && nm_wr.addr == $past(instr_ff.addr))
    else $error("number memory store missing");

  a_dout_sign: assert property (
    do_dout |=> dout_stb && dout_cmd.on == $past(acc_ff[SIGN_B])
      && dout_cmd.chan == $past(instr_ff.addr[DOUT_SEL_W-1:0]))
    else $error("discrete output command wrong");

  a_print_copy: assert property (
    do_print |=> print_word == $past(acc_ff) ##1 periph_word == $past(acc_ff, 2))
    else $error("print path wrong");

  a_din_read: assert property (
    setup && !pwrite && paddr == OFF_DIN |=> prdata == DATA_W'($past(din)))
    else $error("discrete input read wrong");

  a_ain_range: assert property (
    do_ain && !ain_valid |=> acc_ff == '0)
    else $error("unused encoder select not read as zero");

  a_instr_field: assert property (
    wr_instr |=> instr_ff.addr == $past(pwdata[NMAD_W-1:0]))
    else $error("address field not taken from low bits");

  a_tr_write_only: assert property (
    !wr_tr |=> $stable(tr_ff))
    else $error("transfer register changed without a write");

  a_dac_hold: assert property (
    !do_aout |=> $stable(dac_cmd) && !dac_stb)
    else $error("converter command changed without analog out");

  a_dac_range: assert property (
    dac_stb |-> dac_cmd.code != '0)
    else $error("converter code below minus full scale");

  a_store_pair: assert property (
    nm_stb == dac_stb)
    else $error("store strobe apart from converter strobe");

  a_dout_hold: assert property (
    !do_dout |=> $stable(dout_cmd) && !dout_stb)
    else $error("relay command changed without discrete out");

  a_print_hold: assert property (
    !do_print |=> $stable(print_word))
    else $error("print register changed without print");

  a_periph_stage: assert property (
    1'b1 |=> periph_word == $past(print_word))
    else $error("peripheral stage not fed from print register");

  a_acc_kept: assert property (
    !do_ain && !wr_acc |=> $stable(acc_ff))
    else $error("accumulator changed without a cause");

  c_ain: cover property (do_ain ##1 1'b1);
  c_ain_range: cover property (do_ain && !ain_valid);
  c_aout_neg: cover property (do_aout && tr_ff[SIGN_B]);
  c_dout_on: cover property (do_dout && acc_ff[SIGN_B]);
  c_print: cover property (do_print ##2 periph_word != '0);

endmodule // io_instr_unit

// *** io_instr_pkg.sv ***
package io_instr_pkg;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_INSTR  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ACC    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TR     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PRINT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PERIPH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DIN    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

  // ----------------------------------------
  // Word and field layout
  // ----------------------------------------
  localparam int MAG_W      = 20;
  localparam int WORD_W     = MAG_W + 1;
  localparam int SIGN_B     = MAG_W;
  localparam int NMAD_W     = 12;
  localparam int OP_LSB     = NMAD_W;
  localparam int OP_W       = 3;
  localparam int BUSY_B     = OP_W;
  localparam int ENC_W      = 10;
  localparam int AIN_SEL_W  = 7;
  localparam int AOUT_SEL_W = 6;
  localparam int DOUT_SEL_W = 10;
  localparam int DAC_MAG_W  = 11;
  localparam int DAC_W      = 12;
  localparam logic [DAC_W-1:0] DAC_MID = 12'h800;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [OP_W-1:0] {
    op_none                = 3'h0,
    op_mux_analog_in       = 3'h1,
    op_mux_analog_out      = 3'h2,
    op_mux_analog_out_alt  = 3'h3,
    op_mux_discrete_out    = 3'h4,
    op_fast_print          = 3'h5
  } op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01
  } st_t;

  typedef struct packed {
    op_t               op;
    logic [NMAD_W-1:0] addr;
  } instr_t;

  typedef struct packed {
    logic [AOUT_SEL_W-1:0] chan;
    logic [DAC_W-1:0]      code;
  } dac_cmd_t;

  typedef struct packed {
    logic [NMAD_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } nm_wr_t;

  typedef struct packed {
    logic [DOUT_SEL_W-1:0] chan;
    logic                  on;
  } dout_cmd_t;

endpackage

// *** io_far_side.sv ***
`timescale 1ns/10ps
module io_far_side
  import io_instr_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Encoder shafts
  input  wire logic [24*ENC_W-1:0] shaft_angle,
  output logic      [24*ENC_W-1:0] enc_gray,
  // Converter, number memory, relays
  input  wire dac_cmd_t            dac_cmd,
  input  wire logic                dac_stb,
  input  wire nm_wr_t              nm_wr,
  input  wire logic                nm_stb,
  input  wire dout_cmd_t           dout_cmd,
  input  wire logic                dout_stb
);
  // ----------------------------------------
  // Encoders, holds, relays
  // ----------------------------------------
  logic [DAC_W-1:0] hold_ff [64];
  logic [1023:0]    relay_ff;
  nm_wr_t           nm_last_ff;

  // Reflected Gray, each bit xor its upper neighbour
  assign enc_gray = shaft_angle ^ ((shaft_angle >> 1) & {24{10'h1FF}});

  // Holds keep their charge between services, so no reset
  always_ff @(posedge pclk) begin
    if (dac_stb)
      hold_ff[dac_cmd.chan] <= dac_cmd.code;
    if (nm_stb)
      nm_last_ff <= nm_wr;
  end

  // Latching relays clear at reset and otherwise change only when commanded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      relay_ff <= '0;
    else if (dout_stb)
      relay_ff[dout_cmd.chan] <= dout_cmd.on;
  end
endmodule // io_far_side

// *** simulator_io_instruction_unit_tb.sv ***
`timescale 1ns/10ps
module simulator_io_instruction_unit_tb;
  import io_instr_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata, rd, din;
  logic [24*ENC_W-1:0] shaft_angle, enc_gray;
  dac_cmd_t            dac_cmd;
  nm_wr_t              nm_wr;
  dout_cmd_t           dout_cmd;
  logic                dac_stb, nm_stb, dout_stb;
  logic [WORD_W-1:0]   print_word, periph_word, word;
  logic [NMAD_W-1:0]   fa;
  logic [1023:0]       relays;
  int                  n_fail, total_checks;

  io_instr_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_gray(enc_gray), .din(din), .dac_cmd(dac_cmd),
    .dac_stb(dac_stb), .nm_wr(nm_wr), .nm_stb(nm_stb), .dout_cmd(dout_cmd),
    .dout_stb(dout_stb), .print_word(print_word), .periph_word(periph_word));
  io_far_side far (.pclk(pclk), .presetn(presetn), .shaft_angle(shaft_angle),
    .enc_gray(enc_gray), .dac_cmd(dac_cmd), .dac_stb(dac_stb), .nm_wr(nm_wr),
    .nm_stb(nm_stb), .dout_cmd(dout_cmd), .dout_stb(dout_stb));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic issue(input logic [2:0] op, input logic [11:0] a);
    apb(1'b1, OFF_INSTR, {17'h0, op, a});
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Offset binary around mid scale
  function automatic logic [DAC_W-1:0] dac_exp(input logic [WORD_W-1:0] t);
    return t[20] ? DAC_MID - 12'(t[19:9]) : DAC_MID + 12'(t[19:9]);
  endfunction

  // Generous bound: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, din, shaft_angle, relays} = '0;
    n_fail = 0;
    total_checks = 0;
    presetn = 1'b0;
    void'($urandom(26));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_ACC, 32'h0);
    chk(rd, 0);
    for (int k = 0; k < 24; k++)
      shaft_angle[k*ENC_W +: ENC_W] <= 10'($urandom);
    // All ones and the top bit alone run the xor chain end to end
    shaft_angle[0 +: ENC_W]        <= 10'h200;
    shaft_angle[23*ENC_W +: ENC_W] <= 10'h3FF;
    // Every encoder, then selects past the last one
    for (int k = 0; k < 26; k++) begin
      fa = {5'($urandom), (k < 24) ? 7'(k) : ((k == 24) ? 7'h18 : 7'h7F)};
      apb(1'b1, OFF_ACC, $urandom);
      issue(op_mux_analog_in, fa);
      apb(1'b0, OFF_ACC, 32'h0);
      chk(rd, (k < 24) ? {11'h0, shaft_angle[k*ENC_W +: ENC_W], 10'h0} : 0);
    end
    // Scale ends and mid first, then random words
    for (int k = 0; k < 12; k++) begin
      word = (k == 0) ? 21'h1FFFFF : (k == 1) ? 21'h0 : (k == 2) ? 21'h0FFFFF : 21'($urandom);
      fa = 12'($urandom);
      apb(1'b1, OFF_TR, 32'(word));
      issue(k[0] ? op_mux_analog_out_alt : op_mux_analog_out, fa);
      apb(1'b0, OFF_TR, 32'h0);
      chk(rd, word);
      chk(far.hold_ff[fa[5:0]], dac_exp(word));
      chk(far.nm_last_ff, {fa, word});
    end
    // Some channels revisited so a relay is switched to the other state
    for (int k = 0; k < 16; k++) begin
      word = 21'($urandom);
      fa = (k % 4 == 3) ? fa : 12'($urandom);
      // Revisits flip the sign so a relay really changes state
      if (k % 4 == 3)
        word[20] = ~relays[fa[9:0]];
      relays[fa[9:0]] = word[20];
      apb(1'b1, OFF_ACC, 32'(word));
      issue(op_mux_discrete_out, fa);
      apb(1'b0, OFF_DIN, 32'h0);
      chk(|(far.relay_ff ^ relays), 0);
    end
    for (int k = 0; k < 4; k++) begin
      word = 21'($urandom);
      apb(1'b1, OFF_ACC, 32'(word));
      issue(op_fast_print, 12'($urandom));
      apb(1'b0, OFF_PRINT, 32'h0);
      chk(rd, word);
      chk(print_word, word);
      apb(1'b0, OFF_PERIPH, 32'h0);
      chk(rd, word);
      chk(periph_word, word);
    end
    din <= $urandom;
    apb(1'b0, OFF_DIN, 32'h0);
    chk(rd, din);
    // Read-only print register and an unmapped address
    apb(1'b1, OFF_PRINT, ~32'(word));
    apb(1'b0, OFF_PRINT, 32'h0);
    chk(rd, word);
    apb(1'b1, 8'h40, 32'h1234);
    chk(er, 1);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, 64'h1_0000_0000);
    // Spare code 6: no operation is decoded for it, so nothing moves
    fa = 12'($urandom);
    issue(3'h6, fa);
    apb(1'b0, OFF_INSTR, 32'h0);
    chk(rd, {17'h0, 3'h6, fa});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h6);
    chk(print_word, word);
    chk(|(far.relay_ff ^ relays), 0);
    // Reset in mid-run clears the print path and the accumulator
    presetn <= 1'b0;
    @(posedge pclk);
    chk({print_word, periph_word}, 0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_ACC, 32'h0);
    chk(rd, 0);
    end_of_test();
  end
endmodule // simulator_io_instruction_unit_tb
